//--- verilog/io_space_pkg.sv
// Constants and types shared by the I/O register space decoder.
package io_space_pkg;

  localparam int        IO_SPAN       = 64;
  localparam int        EXT_DEPTH     = 160;
  localparam logic [7:0] DATA_IO_BASE = 8'h20;
  localparam logic [7:0] DATA_IO_TOP  = 8'h5F;
  localparam logic [7:0] EXT_BASE     = 8'h60;
  localparam logic [7:0] RESET_BYTE   = 8'h00;

  localparam logic [5:0] OFF_PORT_B_INPUT_LEVEL     = 6'h03;
  localparam logic [5:0] OFF_DIRB     = 6'h04;
  localparam logic [5:0] OFF_OUTB     = 6'h05;
  localparam logic [5:0] OFF_PORT_C_INPUT_LEVEL     = 6'h06;
  localparam logic [5:0] OFF_DIRC     = 6'h07;
  localparam logic [5:0] OFF_OUTC     = 6'h08;
  localparam logic [5:0] OFF_PORT_D_INPUT_LEVEL     = 6'h09;
  localparam logic [5:0] OFF_DIRD     = 6'h0A;
  localparam logic [5:0] OFF_OUTD     = 6'h0B;
  localparam logic [5:0] OFF_PORT_E_INPUT_LEVEL     = 6'h0C;
  localparam logic [5:0] OFF_DIRE     = 6'h0D;
  localparam logic [5:0] OFF_OUTE     = 6'h0E;
  localparam logic [5:0] OFF_T8FLAG   = 6'h15;
  localparam logic [5:0] OFF_T16FLAG  = 6'h16;
  localparam logic [5:0] OFF_SCR1     = 6'h19;
  localparam logic [5:0] OFF_SCR2     = 6'h1A;
  localparam logic [5:0] OFF_SCR3     = 6'h1B;
  localparam logic [5:0] OFF_EXTFLAG  = 6'h1C;
  localparam logic [5:0] OFF_EXTMASK  = 6'h1D;
  localparam logic [5:0] OFF_SCR0     = 6'h1E;
  localparam logic [5:0] OFF_NVCTRL   = 6'h1F;
  localparam logic [5:0] OFF_NVDATA   = 6'h20;
  localparam logic [5:0] OFF_NVADRL   = 6'h21;
  localparam logic [5:0] OFF_NVADRH   = 6'h22;
  localparam logic [5:0] OFF_TGLOB    = 6'h23;
  localparam logic [5:0] OFF_T8CTLA   = 6'h24;
  localparam logic [5:0] OFF_T8CTLB   = 6'h25;
  localparam logic [5:0] OFF_T8CNT    = 6'h26;
  localparam logic [5:0] OFF_T8MA     = 6'h27;
  localparam logic [5:0] OFF_T8MB     = 6'h28;
  localparam logic [5:0] OFF_PLL      = 6'h29;
  localparam logic [5:0] OFF_SPCTL    = 6'h2C;
  localparam logic [5:0] OFF_SPSTAT   = 6'h2D;
  localparam logic [5:0] OFF_SPDATA   = 6'h2E;
  localparam logic [5:0] OFF_CMP      = 6'h30;
  localparam logic [5:0] OFF_MONDATA  = 6'h31;
  localparam logic [5:0] OFF_MONCTL   = 6'h32;
  localparam logic [5:0] OFF_SLEEP    = 6'h33;
  localparam logic [5:0] OFF_RSTCAUSE = 6'h34;
  localparam logic [5:0] OFF_MISC     = 6'h35;
  localparam logic [5:0] BIT_TOP      = 6'h1F;

  localparam logic [7:0] MASK_FULL    = 8'hFF;
  localparam logic [7:0] MASK_PORT_E_OUTPUT   = 8'h07;
  localparam logic [7:0] MASK_T8FLAG  = 8'h07;
  localparam logic [7:0] MASK_T16FLAG = 8'h27;
  localparam logic [7:0] MASK_LOW4    = 8'h0F;
  localparam logic [7:0] MASK_TGLOB   = 8'hC1;
  localparam logic [7:0] MASK_T8CTLA  = 8'hF3;
  localparam logic [7:0] MASK_T8CTLB  = 8'hCF;
  localparam logic [7:0] MASK_PLL     = 8'h07;
  localparam logic [7:0] MASK_SPSTAT  = 8'hC1;
  localparam logic [7:0] MASK_CMP     = 8'hF7;
  localparam logic [7:0] MASK_MISC    = 8'h93;

  typedef enum logic [3:0] {
    OP_SET      = 4'h1,
    OP_CLEAR    = 4'h2,
    OP_SKIP_SET = 4'h4,
    OP_SKIP_CLR = 4'h8
  } bit_op_type;

endpackage

//--- verilog/io_register_space_decoder.sv
// I/O register space: short-form, single-bit and data-space access paths.
//
// Behaviour
// - Short-form I/O reaches 0x00-0x3F; data space sees them at +0x20.
// - Set and clear bit work only on I/O addresses 0x00-0x1F.
// - Skip-if-set and skip-if-clear test one bit in that low range.
// - Writing one clears a status flag unless a hardware event sets it in the same cycle; writing zero leaves it alone.
// - Bit set or clear touches only the addressed bit, nothing else.
// - Extended range 0x60-0xFF is reached only by data-space loads, stores.
// - Short-form address selects exactly 64 locations.
`timescale 1ns/1ps

module io_register_space_decoder (
  input  wire logic                     mclk,
  input  wire logic                     arst_n,
  input  wire logic                     ioReq,
  input  wire logic                     ioWrite,
  input  wire logic [5:0]               ioAddr,
  input  wire logic [7:0]               ioWdata,
  input  wire logic                     bitReq,
  input  wire io_space_pkg::bit_op_type bitOp,
  input  wire logic [4:0]               bitAddr,
  input  wire logic [2:0]               bitSel,
  input  wire logic                     memReq,
  input  wire logic                     memWrite,
  input  wire logic [7:0]               memAddr,
  input  wire logic [7:0]               memWdata,
  input  wire logic [7:0]               portBPins,
  input  wire logic [7:0]               portCPins,
  input  wire logic [7:0]               portDPins,
  input  wire logic [7:0]               portEPins,
  input  wire logic [2:0]               timer8FlagSet,
  input  wire logic [7:0]               timer16FlagSet,
  input  wire logic [3:0]               extIrqFlagSet,
  output logic      [7:0]               rdData_r,
  output logic                          rdValid_r,
  output logic                          testValid_r,
  output logic                          testSkip_r,
  output logic      [7:0]               portBOut,
  output logic      [7:0]               portBDir,
  output logic      [7:0]               portCOut,
  output logic      [7:0]               portCDir,
  output logic      [7:0]               portDOut,
  output logic      [7:0]               portDDir,
  output logic      [7:0]               portEOut,
  output logic      [7:0]               portEDir
);
  import io_space_pkg::*;

  logic [7:0] ioMem_r   [0:IO_SPAN-1];
  logic [7:0] ioMem_nxt [0:IO_SPAN-1];
  logic [7:0] extMem_r  [0:EXT_DEPTH-1];

  logic       ioWe;
  logic [5:0] ioWa;
  logic [7:0] ioWd;
  logic [7:0] ioWm;
  logic       extWe;
  logic [7:0] extIdx;
  logic       rdHit;
  logic [7:0] rdVal;
  logic       memIo;
  logic       memExt;
  logic [5:0] memIoAddr;
  logic [7:0] bitView;
  logic       bitHit;

  // Bits that hold state; everything else except the pin registers is reserved and reads zero.
  function automatic logic [7:0] implMask(input logic [5:0] a);
    case (a)
      OFF_DIRB, OFF_OUTB, OFF_DIRC, OFF_OUTC,
      OFF_DIRD, OFF_OUTD,
      OFF_SCR0, OFF_SCR1, OFF_SCR2, OFF_SCR3,
      OFF_NVDATA, OFF_NVADRL, OFF_T8CNT, OFF_T8MA, OFF_T8MB,
      OFF_SPCTL, OFF_SPDATA, OFF_MONDATA, OFF_MONCTL:
        implMask = MASK_FULL;
      OFF_DIRE, OFF_OUTE:   implMask = MASK_PORT_E_OUTPUT;
      OFF_T8FLAG:           implMask = MASK_T8FLAG;
      OFF_T16FLAG:          implMask = MASK_T16FLAG;
      OFF_EXTFLAG, OFF_EXTMASK, OFF_NVCTRL, OFF_NVADRH,
      OFF_SLEEP, OFF_RSTCAUSE:
        implMask = MASK_LOW4;
      OFF_TGLOB:            implMask = MASK_TGLOB;
      OFF_T8CTLA:           implMask = MASK_T8CTLA;
      OFF_T8CTLB:           implMask = MASK_T8CTLB;
      OFF_PLL:              implMask = MASK_PLL;
      OFF_SPSTAT:           implMask = MASK_SPSTAT;
      OFF_CMP:              implMask = MASK_CMP;
      OFF_MISC:             implMask = MASK_MISC;
      default:              implMask = 8'h00;
    endcase
  endfunction

  // Status flags that software clears by writing one.
  function automatic logic [7:0] w1cMask(input logic [5:0] a);
    case (a)
      OFF_T8FLAG:  w1cMask = MASK_T8FLAG;
      OFF_T16FLAG: w1cMask = MASK_T16FLAG;
      OFF_EXTFLAG: w1cMask = MASK_LOW4;
      default:     w1cMask = 8'h00;
    endcase
  endfunction

  // Event bits raised by the peripherals into the flag registers.
  function automatic logic [7:0] hwSet(input logic [5:0] a);
    case (a)
      OFF_T8FLAG:  hwSet = {5'h00, timer8FlagSet} & MASK_T8FLAG;
      OFF_T16FLAG: hwSet = timer16FlagSet & MASK_T16FLAG;
      OFF_EXTFLAG: hwSet = {4'h0, extIrqFlagSet};
      default:     hwSet = 8'h00;
    endcase
  endfunction

  // Read view of one I/O location; pin registers show the live inputs.
  function automatic logic [7:0] readIo(input logic [5:0] a);
    case (a)
      OFF_PORT_B_INPUT_LEVEL: readIo = portBPins;
      OFF_PORT_C_INPUT_LEVEL: readIo = portCPins;
      OFF_PORT_D_INPUT_LEVEL: readIo = portDPins;
      OFF_PORT_E_INPUT_LEVEL: readIo = portEPins & MASK_PORT_E_OUTPUT;
      default:  readIo = ioMem_r[a] & implMask(a);
    endcase
  endfunction

  // Byte and bit seen by the skip tests; a process rather than an assign so
  // that a change of a stored byte or a pin re-evaluates the view.
  always_comb begin
    bitView = readIo({1'b0, bitAddr});
    bitHit  = bitView[bitSel];
  end

  // Merge a masked write into a stored byte.
  function automatic logic [7:0] applyWrite(input logic [7:0] old,
                                            input logic [7:0] wd,
                                            input logic [7:0] wm,
                                            input logic [5:0] a);
    logic [7:0] rw;
    logic [7:0] wc;
    rw = wm & implMask(a) & ~w1cMask(a);
    wc = wm & w1cMask(a);
    applyWrite = ((old & ~rw) | (wd & rw)) & ~(wd & wc);
  endfunction

  // Data-space decode: the core's own register file sits below the mirror.
  always_comb begin
    memIo     = (memAddr >= DATA_IO_BASE) && (memAddr <= DATA_IO_TOP);
    memExt    = (memAddr >= EXT_BASE);
    memIoAddr = 6'(memAddr - DATA_IO_BASE);
  end

  // One access per cycle; short-form I/O wins over bit ops over data space.
  always_comb begin
    ioWe   = 1'b0;
    ioWa   = 6'h00;
    ioWd   = 8'h00;
    ioWm   = 8'h00;
    extWe  = 1'b0;
    extIdx = 8'(memAddr - EXT_BASE);
    rdHit  = 1'b0;
    rdVal  = 8'h00;
    if (ioReq) begin
      // A six-bit field can never name the extended range.
      ioWa  = ioAddr;
      ioWe  = ioWrite;
      ioWd  = ioWdata;
      ioWm  = MASK_FULL;
      rdHit = !ioWrite;
      rdVal = readIo(ioAddr);
    end else if (bitReq) begin
      ioWa = {1'b0, bitAddr};
      ioWe = (bitOp == OP_SET) || (bitOp == OP_CLEAR);
      ioWm = 8'h01 << bitSel;
      ioWd = (bitOp == OP_SET) ? MASK_FULL : 8'h00;
    end else if (memReq) begin
      if (memIo) begin
        ioWa  = memIoAddr;
        ioWe  = memWrite;
        ioWd  = memWdata;
        ioWm  = MASK_FULL;
        rdHit = !memWrite;
        rdVal = readIo(memIoAddr);
      end else if (memExt) begin
        extWe = memWrite;
        rdHit = !memWrite;
        rdVal = extMem_r[extIdx];
      end else begin
        rdHit = !memWrite;
      end
    end
  end

  // Hardware events are merged after the write so that set beats clear.
  always_comb begin
    for (int i = 0; i < IO_SPAN; i++) begin
      ioMem_nxt[i] = ioMem_r[i];
      if (ioWe && (ioWa == 6'(i))) begin
        ioMem_nxt[i] = applyWrite(ioMem_r[i], ioWd, ioWm, 6'(i));
      end
      ioMem_nxt[i] = ioMem_nxt[i] | hwSet(6'(i));
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < IO_SPAN; i++) begin
        ioMem_r[i] <= RESET_BYTE;
      end
    end else begin
      for (int i = 0; i < IO_SPAN; i++) begin
        ioMem_r[i] <= ioMem_nxt[i];
      end
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < EXT_DEPTH; i++) begin
        extMem_r[i] <= RESET_BYTE;
      end
    end else if (extWe) begin
      extMem_r[extIdx] <= memWdata;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rdData_r  <= 8'h00;
      rdValid_r <= 1'b0;
    end else begin
      rdValid_r <= rdHit;
      rdData_r  <= rdHit ? rdVal : 8'h00;
    end
  end

  // Bit tests read the same view as a byte read of that location.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      testValid_r <= 1'b0;
      testSkip_r  <= 1'b0;
    end else begin
      testValid_r <= !ioReq && bitReq &&
                     ((bitOp == OP_SKIP_SET) || (bitOp == OP_SKIP_CLR));
      testSkip_r  <= !ioReq && bitReq &&
                     (((bitOp == OP_SKIP_SET) && bitHit) ||
                      ((bitOp == OP_SKIP_CLR) && !bitHit));
    end
  end

  assign portBDir = ioMem_r[OFF_DIRB];
  assign portBOut = ioMem_r[OFF_OUTB];
  assign portCDir = ioMem_r[OFF_DIRC];
  assign portCOut = ioMem_r[OFF_OUTC];
  assign portDDir = ioMem_r[OFF_DIRD];
  assign portDOut = ioMem_r[OFF_OUTD];
  assign portEDir = ioMem_r[OFF_DIRE];
  assign portEOut = ioMem_r[OFF_OUTE];

  logic noHwSet;
  assign noHwSet = (timer8FlagSet == 3'h0) && (timer16FlagSet == 8'h00) &&
                   (extIrqFlagSet == 4'h0);

  a_io_read_answer: assert property (
    @(posedge mclk) disable iff (!arst_n)
    (ioReq && !ioWrite) |=> rdValid_r && (rdData_r == $past(rdVal)))
    else $error("short-form read answer wrong");

  a_mirror_write: assert property (
    @(posedge mclk) disable iff (!arst_n)
    (!ioReq && !bitReq && memReq && memWrite && memIo &&
     (w1cMask(memIoAddr) == 8'h00))
    |=> ((ioMem_r[$past(memIoAddr)] ^ $past(memWdata))
         & implMask($past(memIoAddr))) == 8'h00)
    else $error("data-space mirror write lost");

  a_bit_single: assert property (
    @(posedge mclk) disable iff (!arst_n)
    (!ioReq && bitReq && noHwSet &&
     ((bitOp == OP_SET) || (bitOp == OP_CLEAR)))
    |=> ((ioMem_r[$past(bitAddr)] ^ $past(ioMem_r[bitAddr]))
         & ~(8'h01 << $past(bitSel))) == 8'h00)
    else $error("bit operation touched other bits");

  a_bit_set_rw: assert property (
    @(posedge mclk) disable iff (!arst_n)
    (!ioReq && bitReq && (bitOp == OP_SET) &&
     (implMask({1'b0, bitAddr}) & ~w1cMask({1'b0, bitAddr}) &
      (8'h01 << bitSel)) != 8'h00)
    |=> ioMem_r[$past(bitAddr)][$past(bitSel)])
    else $error("set bit did not set");

  a_skip_result: assert property (
    @(posedge mclk) disable iff (!arst_n)
    (!ioReq && bitReq && (bitOp == OP_SKIP_CLR))
    |=> testValid_r &&
        (testSkip_r == !$past(bitHit)))
    else $error("skip-if-clear result wrong");

  a_w1c_clear: assert property (
    @(posedge mclk) disable iff (!arst_n)
    (ioReq && ioWrite && noHwSet)
    |=> (ioMem_r[$past(ioAddr)] & $past(ioWdata) &
         w1cMask($past(ioAddr))) == 8'h00)
    else $error("flag not cleared by one");

  a_flag_set_wins: assert property (
    @(posedge mclk) disable iff (!arst_n)
    (extIrqFlagSet != 4'h0) |=>
    (ioMem_r[OFF_EXTFLAG][3:0] & $past(extIrqFlagSet)) ==
    $past(extIrqFlagSet))
    else $error("flag event lost");

  a_ext_only_mem: assert property (
    @(posedge mclk) disable iff (!arst_n)
    extWe |-> (!ioReq && !bitReq && memReq && (memAddr >= EXT_BASE)))
    else $error("extended range reached wrongly");

  a_reserved_zero: assert property (
    @(posedge mclk) disable iff (!arst_n)
    (ioReq && !ioWrite && (implMask(ioAddr) == 8'h00) &&
     (ioAddr != OFF_PORT_B_INPUT_LEVEL) && (ioAddr != OFF_PORT_C_INPUT_LEVEL) &&
     (ioAddr != OFF_PORT_D_INPUT_LEVEL) && (ioAddr != OFF_PORT_E_INPUT_LEVEL))
    |=> rdValid_r && (rdData_r == 8'h00))
    else $error("reserved location not zero");

  // Flag bits are left out: a clear-bit operation does nothing to them.
  a_bit_clear_rw: assert property (
    @(posedge mclk) disable iff (!arst_n)
    (!ioReq && bitReq && noHwSet && (bitOp == OP_CLEAR) &&
     (w1cMask({1'b0, bitAddr}) == 8'h00))
    |=> !ioMem_r[$past(bitAddr)][$past(bitSel)])
    else $error("clear bit did not clear");

  a_bit_upper_kept: assert property (
    @(posedge mclk) disable iff (!arst_n)
    (!ioReq && bitReq)
    |=> ioMem_r[{1'b1, $past(bitAddr)}] == $past(ioMem_r[{1'b1, bitAddr}]))
    else $error("bit operation reached upper range");

  a_skip_set: assert property (
    @(posedge mclk) disable iff (!arst_n)
    (!ioReq && bitReq && (bitOp == OP_SKIP_SET))
    |=> testValid_r && (testSkip_r == $past(bitHit)))
    else $error("skip-if-set result wrong");

  a_test_only_skip: assert property (
    @(posedge mclk) disable iff (!arst_n)
    testValid_r |-> $past(!ioReq && bitReq &&
                          ((bitOp == OP_SKIP_SET) ||
                           (bitOp == OP_SKIP_CLR))))
    else $error("bit test answer without request");

  a_test_quiet: assert property (
    @(posedge mclk) disable iff (!arst_n)
    !testValid_r |-> !testSkip_r)
    else $error("skip result outside its answer");

  a_read_quiet: assert property (
    @(posedge mclk) disable iff (!arst_n)
    !rdValid_r |-> (rdData_r == 8'h00))
    else $error("read data outside its answer");

  a_low_mem_zero: assert property (
    @(posedge mclk) disable iff (!arst_n)
    (!ioReq && !bitReq && memReq && !memWrite && (memAddr < DATA_IO_BASE))
    |=> rdValid_r && (rdData_r == 8'h00))
    else $error("load below mirror not zero");

  a_reserved_write: assert property (
    @(posedge mclk) disable iff (!arst_n)
    (ioReq && ioWrite && (implMask(ioAddr) == 8'h00))
    |=> ioMem_r[$past(ioAddr)] == 8'h00)
    else $error("reserved location took a write");

  a_ext_store: assert property (
    @(posedge mclk) disable iff (!arst_n)
    (!ioReq && !bitReq && memReq && memWrite && (memAddr >= EXT_BASE))
    |=> extMem_r[$past(memAddr - EXT_BASE)] == $past(memWdata))
    else $error("extended store lost");

endmodule

//--- testbench/core_access_model.sv
// Behavioural model of the core unit that issues register accesses.
`timescale 1ns/1ps

module core_access_model
  import io_space_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic [7:0] rdData_r,
  input  wire logic       rdValid_r,
  input  wire logic       testValid_r,
  input  wire logic       testSkip_r,
  output logic            ioReq,
  output logic            ioWrite,
  output logic [5:0]      ioAddr,
  output logic [7:0]      ioWdata,
  output logic            bitReq,
  output io_space_pkg::bit_op_type bitOp,
  output logic [4:0]      bitAddr,
  output logic [2:0]      bitSel,
  output logic            memReq,
  output logic            memWrite,
  output logic [7:0]      memAddr,
  output logic [7:0]      memWdata
);
  import io_space_pkg::*;

  // Released fields carry the inverse of the last value so that a stale
  // address or data byte can never look like a valid one.
  task automatic idle(input logic [7:0] a, input logic [7:0] d);
    ioReq    <= 1'b0;
    bitReq   <= 1'b0;
    memReq   <= 1'b0;
    ioWrite  <= 1'b0;
    memWrite <= 1'b0;
    ioAddr   <= ~a[5:0];
    bitAddr  <= ~a[4:0];
    memAddr  <= ~a;
    ioWdata  <= ~d;
    memWdata <= ~d;
    bitSel   <= ~d[2:0];
    bitOp    <= OP_SET;
  endtask

  initial begin
    idle(8'h00, 8'h00);
  end

  // Kind 0 is short-form I/O, 1 a single-bit op, 2 a data-space access.
  task automatic access(input int kind, input logic wr, input logic [7:0] a,
                        input logic [7:0] d, input bit_op_type op,
                        output logic [7:0] q);
    q = 'x;
    @(posedge mclk);
    ioReq    <= (kind == 0);
    bitReq   <= (kind == 1);
    memReq   <= (kind == 2);
    ioWrite  <= wr;
    memWrite <= wr;
    ioAddr   <= a[5:0];
    bitAddr  <= a[4:0];
    memAddr  <= a;
    bitOp    <= op;
    bitSel   <= d[2:0];
    ioWdata  <= d;
    memWdata <= d;
    @(posedge mclk);
    idle(a, d);
    for (int n = 0; n < 3; n++) begin
      #1;
      if (rdValid_r === 1'b1) q = rdData_r;
      if (testValid_r === 1'b1) q = {7'h00, testSkip_r};
      if (!$isunknown(q)) break;
      @(posedge mclk);
    end
  endtask
endmodule

//--- testbench/io_register_space_decoder_tb_top.sv
// Self-checking bench for the I/O register space decoder.
`timescale 1ns/1ps

`define CHK(what, exp, got) \
  begin \
    samples_checked++; \
    if ((got) !== (exp)) begin \
      miscompares++; \
      $display("Error %s expected %h seen %h", what, exp, got); \
    end \
  end

module io_register_space_decoder_tb_top;
  import io_space_pkg::*;

  logic       mclk, arst_n, ioReq, ioWrite, bitReq, memReq, memWrite;
  logic       rdValid_r, testValid_r, testSkip_r;
  logic [5:0] ioAddr;
  logic [4:0] bitAddr, a5;
  logic [2:0] bitSel, timer8FlagSet, s;
  logic [3:0] extIrqFlagSet;
  logic [1:0] w;
  logic [7:0] ioWdata, memAddr, memWdata, rdData_r, timer16FlagSet;
  logic [7:0] portBPins, portCPins, portDPins, portEPins, x, d, q, r, e;
  logic [7:0] portBOut, portBDir, portCOut, portCDir;
  logic [7:0] portDOut, portDDir, portEOut, portEDir;
  logic [63:0] pv, po;
  bit_op_type bitOp, op;
  logic [7:0] sh [64];
  logic [7:0] ext [160];
  logic [4:0] hot [3] = '{5'h15, 5'h16, 5'h1C};
  integer     seed = 32'hEDF183C2;
  int         miscompares = 0;
  int         samples_checked = 0;
  int         i;

  io_register_space_decoder uut (.mclk, .arst_n, .ioReq, .ioWrite, .ioAddr,
    .ioWdata, .bitReq, .bitOp, .bitAddr, .bitSel, .memReq, .memWrite,
    .memAddr, .memWdata, .portBPins, .portCPins, .portDPins, .portEPins,
    .timer8FlagSet, .timer16FlagSet, .extIrqFlagSet, .rdData_r, .rdValid_r,
    .testValid_r, .testSkip_r, .portBOut, .portBDir, .portCOut, .portCDir,
    .portDOut, .portDDir, .portEOut, .portEDir);

  core_access_model m (.mclk, .rdData_r, .rdValid_r, .testValid_r,
    .testSkip_r, .ioReq, .ioWrite, .ioAddr, .ioWdata, .bitReq, .bitOp,
    .bitAddr, .bitSel, .memReq, .memWrite, .memAddr, .memWdata);

  function automatic logic [7:0] msk(input logic [5:0] a);
    case (a)
      6'h03, 6'h04, 6'h05, 6'h06, 6'h07, 6'h08, 6'h09, 6'h0A, 6'h0B, 6'h19,
      6'h1A, 6'h1B, 6'h1E, 6'h20, 6'h21, 6'h26, 6'h27, 6'h28, 6'h2C, 6'h2E,
      6'h31, 6'h32: return MASK_FULL;
      6'h0C, 6'h0D, 6'h0E: return MASK_PORT_E_OUTPUT;
      6'h15: return MASK_T8FLAG;
      6'h16: return MASK_T16FLAG;
      6'h1C, 6'h1D, 6'h1F, 6'h22, 6'h33, 6'h34: return MASK_LOW4;
      6'h23: return MASK_TGLOB;
      6'h24: return MASK_T8CTLA;
      6'h25: return MASK_T8CTLB;
      6'h29: return MASK_PLL;
      6'h2D: return MASK_SPSTAT;
      6'h30: return MASK_CMP;
      6'h35: return MASK_MISC;
      default: return 8'h00;
    endcase
  endfunction

  function automatic logic ro(input logic [5:0] a);
    return a inside {6'h03, 6'h06, 6'h09, 6'h0C};
  endfunction

  function automatic logic w1c(input logic [5:0] a);
    return a inside {6'h15, 6'h16, 6'h1C};
  endfunction

  function automatic logic [7:0] rdExp(input logic [5:0] a);
    case (a)
      6'h03: return portBPins;
      6'h06: return portCPins;
      6'h09: return portDPins;
      6'h0C: return portEPins & MASK_PORT_E_OUTPUT;
      default: return sh[a];
    endcase
  endfunction

  function automatic void wrExp(input logic [5:0] a, input logic [7:0] v);
    if (w1c(a)) sh[a] &= ~v;
    else if (!ro(a)) sh[a] = v & msk(a);
  endfunction

  function automatic logic [7:0] memExp(input logic [7:0] y);
    if (y < DATA_IO_BASE) return 8'h00;
    if (y < EXT_BASE) return rdExp(6'(y - DATA_IO_BASE));
    return ext[y - EXT_BASE];
  endfunction

  function automatic void memWr(input logic [7:0] y, input logic [7:0] v);
    if (y >= EXT_BASE) ext[y - EXT_BASE] = v;
    else if (y >= DATA_IO_BASE) wrExp(6'(y - DATA_IO_BASE), v);
  endfunction

  function automatic void bitExp(input logic [5:0] a, input bit_op_type o,
                                 input logic [2:0] b);
    if (o == OP_SET && w1c(a)) sh[a] &= ~(8'h01 << b);
    else if (o == OP_SET && !ro(a)) sh[a] |= (8'h01 << b) & msk(a);
    else if (o == OP_CLEAR && !w1c(a) && !ro(a)) sh[a] &= ~(8'h01 << b);
  endfunction

  // The events land in the same cycle as a write-one clear of the external
  // flags, so the set must win there.
  task automatic pulse();
    fork
      m.access(0, 1'b1, 8'h1C, MASK_LOW4, OP_SET, q);
      begin
        @(posedge mclk);
        timer8FlagSet  <= 3'h7;
        timer16FlagSet <= 8'hFF;
        extIrqFlagSet  <= 4'hF;
        @(posedge mclk);
        timer8FlagSet  <= 3'h0;
        timer16FlagSet <= 8'h00;
        extIrqFlagSet  <= 4'h0;
      end
    join
    sh[6'h15] |= MASK_T8FLAG;
    sh[6'h16] |= MASK_T16FLAG;
    sh[6'h1C] |= MASK_LOW4;
  endtask

  task automatic ds(input logic [7:0] y, input logic wr, input logic [7:0] v,
                    input logic viaIo, output logic [7:0] res);
    if (viaIo && y >= DATA_IO_BASE && y <= DATA_IO_TOP)
      m.access(0, wr, y - DATA_IO_BASE, v, OP_SET, res);
    else
      m.access(2, wr, y, v, OP_SET, res);
  endtask

  task automatic test_done();
    $display("Checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  initial begin
    #(20 * 40000);
    miscompares++;
    $display("Error watchdog expected done seen hang");
    test_done();
  end

  initial begin
    arst_n = 1'b0;
    {portBPins, portCPins, portDPins, portEPins} = 32'h0000_0000;
    {timer8FlagSet, timer16FlagSet, extIrqFlagSet} = 15'h0000;
    for (i = 0; i < 64; i++) sh[i] = 8'h00;
    for (i = 0; i < 160; i++) ext[i] = 8'h00;
    repeat (6) @(posedge mclk);
    arst_n <= 1'b1;
    for (i = 0; i < 64; i++) begin
      m.access(0, 1'b0, 8'(i), 8'h00, OP_SET, q);
      `CHK("resetRead", 8'h00, q)
    end
    // Mixed paths: 400 random addresses, written and read back by independently chosen paths.
    for (i = 0; i < 400; i++) begin
      x = 8'($random(seed));
      d = 8'($random(seed));
      w = 2'($random(seed));
      @(posedge mclk);
      portBPins <= 8'($random(seed));
      portCPins <= 8'($random(seed));
      portDPins <= 8'($random(seed));
      portEPins <= 8'($random(seed));
      ds(x, 1'b1, d, w[0], q);
      memWr(x, d);
      ds(x, 1'b0, 8'h00, w[1], q);
      `CHK("dataRead", memExp(x), q)
    end
    pulse();
    m.access(0, 1'b1, 8'h15, 8'h00, OP_SET, q);
    m.access(0, 1'b1, 8'h16, 8'h02, OP_SET, q);
    wrExp(6'h15, 8'h00);
    wrExp(6'h16, 8'h02);
    m.access(0, 1'b0, 8'h15, 8'h00, OP_SET, q);
    `CHK("flagKeep", 8'h07, q)
    m.access(0, 1'b0, 8'h16, 8'h00, OP_SET, q);
    `CHK("flagClear", 8'h25, q)
    for (i = 0; i < 240; i++) begin
      a5 = i[0] ? hot[i % 3] : 5'($random(seed));
      s = 3'($random(seed));
      op = bit_op_type'(4'h1 << 2'($random(seed)));
      if (i % 24 == 0) pulse();
      r = rdExp({1'b0, a5});
      m.access(1, 1'b0, {3'b000, a5}, {5'h00, s}, op, q);
      if (op == OP_SKIP_SET || op == OP_SKIP_CLR) begin
        e = {7'h00, r[s] ^ (op == OP_SKIP_CLR)};
        `CHK("skipTest", e, q)
      end
      bitExp({1'b0, a5}, op, s);
      m.access(0, 1'b0, {3'b000, a5}, 8'h00, OP_SET, q);
      `CHK("bitByte", rdExp({1'b0, a5}), q)
    end
    pv = {sh[6'h05], sh[6'h04], sh[6'h08], sh[6'h07],
          sh[6'h0B], sh[6'h0A], sh[6'h0E], sh[6'h0D]};
    po = {portBOut, portBDir, portCOut, portCDir,
          portDOut, portDDir, portEOut, portEDir};
    `CHK("portOut", pv, po)
    test_done();
  end
endmodule
